/* hw/lsx_ea_calc.sv */
`timescale 1ns/1ps
// Effective address base: X, I and B bits select the P/B/X sum
module lsx_ea_calc (
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input wire logic [15:0] reg_b,
    input wire logic [15:0] reg_x,
    output logic [15:0] base_addr,
    output logic indirect,
    output logic post_index
);
    wire logic [15:0] disp = {{8{instr[7]}}, instr[7:0]};
    wire logic bx = instr[lsx_pkg::BIT_X];
    wire logic bi = instr[lsx_pkg::BIT_I];
    wire logic bb = instr[lsx_pkg::BIT_B];
    wire logic [15:0] pb = bb ? reg_b : pc;
    // Direct X alone is X-relative; X with B adds all three
    wire logic [15:0] xsum = bb ? 16'(reg_x + reg_b + disp) : 16'(reg_x + disp);
    assign base_addr = (bx && !bi) ? xsum : 16'(pb + disp);
    assign indirect = bi;
    assign post_index = bx && bi;
endmodule

/* hw/lsx_exec.sv */
`timescale 1ns/1ps
// How it works
// - store_zero writes an all-zero word to the effective location, about 1.3 us.
// - store_accumulator writes A to the effective location, registers untouched.
// - store_temp_reg writes T to the effective location only.
// - store_index writes X to the effective location.
// - store_index may index its address by the current X value.
// - store_double writes A at the location, D at location plus one, 2.2 us.
// - store_float writes three words, exponent first at the effective location.
// - increment_skip_zero reads the word, adds one, writes it back.
// - A zero result skips the next instruction; 2.9 us, else 2.6 us.
// - load_accumulator reads the effective word into A, about 1.0 us.
// - load_temp_reg reads the effective word into T.
// - load_index reads the effective word into X.
// - load_index forms its address from old X before X is overwritten.
// - load_double loads A from the location and D from the next, 1.6 us.
// - load_float loads T, A, D from three consecutive words.
// - Indirect modes fetch a full 16-bit pointer from the relative address.
// - Direct B-relative indexed adds X, B and displacement.
module lsx_exec (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input wire logic [15:0] reg_b,
    input wire logic [15:0] a_in,
    input wire logic [15:0] d_in,
    input wire logic [15:0] t_in,
    input wire logic [15:0] x_in,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic skip,
    output logic illegal,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic a_we,
    output logic [15:0] a_out,
    output logic d_we,
    output logic [15:0] d_out,
    output logic t_we,
    output logic [15:0] t_out,
    output logic x_we,
    output logic [15:0] x_out
);
    lsx_pkg::lsx_state_t state_r;
    logic [4:0] op_r;
    logic [15:0] ea_r;
    logic [15:0] x_old_r;
    logic [1:0] idx_r;
    logic [7:0] cyc_r;
    logic skip_pend_r;
    logic [15:0] a_hold_r;
    logic [15:0] d_hold_r;
    logic [15:0] t_hold_r;
    logic busy_r;
    logic done_r;
    logic skip_r;
    logic illegal_r;
    logic mem_req_r;
    logic mem_we_r;
    logic [15:0] mem_addr_r;
    logic [15:0] mem_wdata_r;
    logic a_we_r;
    logic d_we_r;
    logic t_we_r;
    logic x_we_r;
    logic [15:0] a_out_r;
    logic [15:0] d_out_r;
    logic [15:0] t_out_r;
    logic [15:0] x_out_r;

    wire logic [15:0] base_addr;
    wire logic indirect;
    wire logic post_index;
    lsx_ea_calc u_ea (
        .instr(instr),
        .pc(pc),
        .reg_b(reg_b),
        .reg_x(x_in),
        .base_addr(base_addr),
        .indirect(indirect),
        .post_index(post_index)
    );

    wire logic [4:0] opc = instr[lsx_pkg::OPC_HI:lsx_pkg::OPC_LO];
    wire logic known = (opc <= lsx_pkg::OPC_LOAD_INDEX);
    wire logic is_store = (op_r <= lsx_pkg::OPC_STORE_DOUBLE) || (op_r == lsx_pkg::OPC_STORE_FLOAT);
    wire logic is_inc = (op_r == lsx_pkg::OPC_INC_SKIP);
    wire logic [1:0] nwords = (op_r == lsx_pkg::OPC_STORE_FLOAT || op_r == lsx_pkg::OPC_LOAD_FLOAT)
        ? 2'd3 : (op_r == lsx_pkg::OPC_STORE_DOUBLE || op_r == lsx_pkg::OPC_LOAD_DOUBLE)
        ? 2'd2 : 2'd1;
    wire logic last_word = (idx_r == 2'(nwords - 2'd1));
    wire logic [15:0] cur_addr = 16'(ea_r + {14'h0000, idx_r});
    wire logic [15:0] inc_word = 16'(mem_rdata + lsx_pkg::WORD_ONE);
    // Float words in memory order: exponent (T), then A, then D
    wire logic [15:0] store_word =
        (op_r == lsx_pkg::OPC_STORE_ZERO) ? lsx_pkg::WORD_ZERO :
        (op_r == lsx_pkg::OPC_STORE_ACC) ? a_hold_r :
        (op_r == lsx_pkg::OPC_STORE_TEMP) ? t_hold_r :
        (op_r == lsx_pkg::OPC_STORE_INDEX) ? x_old_r :
        (op_r == lsx_pkg::OPC_STORE_DOUBLE) ? (idx_r == 2'd0 ? a_hold_r : d_hold_r) :
        (idx_r == 2'd0) ? t_hold_r : (idx_r == 2'd1) ? a_hold_r : d_hold_r;
    wire logic [7:0] target_cyc =
        (op_r == lsx_pkg::OPC_STORE_DOUBLE) ? lsx_pkg::CYC_STORE_DOUBLE :
        (op_r == lsx_pkg::OPC_STORE_FLOAT) ? lsx_pkg::CYC_STORE_FLOAT :
        (op_r == lsx_pkg::OPC_LOAD_DOUBLE) ? lsx_pkg::CYC_LOAD_DOUBLE :
        (op_r == lsx_pkg::OPC_LOAD_FLOAT) ? lsx_pkg::CYC_LOAD_FLOAT :
        is_inc ? (skip_pend_r ? lsx_pkg::CYC_INC_SKIP : lsx_pkg::CYC_INC_NOSKIP) :
        is_store ? lsx_pkg::CYC_STORE : lsx_pkg::CYC_LOAD;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= lsx_pkg::ST_IDLE;
            op_r <= 5'h00;
            ea_r <= lsx_pkg::REG_RESET;
            x_old_r <= lsx_pkg::REG_RESET;
            idx_r <= 2'd0;
            cyc_r <= 8'h00;
            skip_pend_r <= 1'b0;
            a_hold_r <= lsx_pkg::REG_RESET;
            d_hold_r <= lsx_pkg::REG_RESET;
            t_hold_r <= lsx_pkg::REG_RESET;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            skip_r <= 1'b0;
            illegal_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= lsx_pkg::REG_RESET;
            mem_wdata_r <= lsx_pkg::REG_RESET;
            a_we_r <= 1'b0;
            d_we_r <= 1'b0;
            t_we_r <= 1'b0;
            x_we_r <= 1'b0;
            a_out_r <= lsx_pkg::REG_RESET;
            d_out_r <= lsx_pkg::REG_RESET;
            t_out_r <= lsx_pkg::REG_RESET;
            x_out_r <= lsx_pkg::REG_RESET;
        end
        else
        begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
            illegal_r <= 1'b0;
            a_we_r <= 1'b0;
            d_we_r <= 1'b0;
            t_we_r <= 1'b0;
            x_we_r <= 1'b0;
            if (busy_r)
            begin
                cyc_r <= 8'(cyc_r + 8'h01);
            end
            case (state_r)
                lsx_pkg::ST_IDLE:
                begin
                    if (start && !known)
                    begin
                        illegal_r <= 1'b1;
                    end
                    else if (start)
                    begin
                        // Operands captured now; X loaded later cannot move the address
                        op_r <= opc;
                        x_old_r <= x_in;
                        a_hold_r <= a_in;
                        d_hold_r <= d_in;
                        t_hold_r <= t_in;
                        ea_r <= base_addr;
                        idx_r <= 2'd0;
                        cyc_r <= 8'h01;
                        skip_pend_r <= 1'b0;
                        busy_r <= 1'b1;
                        if (indirect)
                        begin
                            mem_req_r <= 1'b1;
                            mem_we_r <= 1'b0;
                            mem_addr_r <= base_addr;
                            state_r <= lsx_pkg::ST_PTR_WAIT;
                        end
                        else
                        begin
                            state_r <= lsx_pkg::ST_XFER;
                        end
                    end
                end
                lsx_pkg::ST_PTR_WAIT:
                begin
                    if (mem_ack)
                    begin
                        mem_req_r <= 1'b0;
                        // Pointer is a full word; post-index adds old X
                        ea_r <= post_index ? 16'(mem_rdata + x_old_r) : mem_rdata;
                        state_r <= lsx_pkg::ST_XFER;
                    end
                end
                lsx_pkg::ST_XFER:
                begin
                    mem_req_r <= 1'b1;
                    mem_addr_r <= cur_addr;
                    mem_we_r <= is_store;
                    mem_wdata_r <= store_word;
                    state_r <= lsx_pkg::ST_XFER_WAIT;
                end
                lsx_pkg::ST_XFER_WAIT:
                begin
                    if (mem_ack)
                    begin
                        mem_req_r <= 1'b0;
                        mem_we_r <= 1'b0;
                        if (is_inc)
                        begin
                            mem_wdata_r <= inc_word;
                            skip_pend_r <= (inc_word == lsx_pkg::WORD_ZERO);
                            state_r <= lsx_pkg::ST_INC_WRITE;
                        end
                        else
                        begin
                            if (!is_store)
                            begin
                                case (op_r)
                                    lsx_pkg::OPC_LOAD_ACC:
                                    begin
                                        a_we_r <= 1'b1;
                                        a_out_r <= mem_rdata;
                                    end
                                    lsx_pkg::OPC_LOAD_TEMP:
                                    begin
                                        t_we_r <= 1'b1;
                                        t_out_r <= mem_rdata;
                                    end
                                    lsx_pkg::OPC_LOAD_INDEX:
                                    begin
                                        x_we_r <= 1'b1;
                                        x_out_r <= mem_rdata;
                                    end
                                    lsx_pkg::OPC_LOAD_DOUBLE:
                                    begin
                                        if (idx_r == 2'd0)
                                        begin
                                            a_we_r <= 1'b1;
                                            a_out_r <= mem_rdata;
                                        end
                                        else
                                        begin
                                            d_we_r <= 1'b1;
                                            d_out_r <= mem_rdata;
                                        end
                                    end
                                    default:
                                    begin
                                        // Float load: T, A, D in address order
                                        t_we_r <= (idx_r == 2'd0);
                                        a_we_r <= (idx_r == 2'd1);
                                        d_we_r <= (idx_r == 2'd2);
                                        t_out_r <= (idx_r == 2'd0) ? mem_rdata : t_out_r;
                                        a_out_r <= (idx_r == 2'd1) ? mem_rdata : a_out_r;
                                        d_out_r <= (idx_r == 2'd2) ? mem_rdata : d_out_r;
                                    end
                                endcase
                            end
                            if (last_word)
                            begin
                                state_r <= lsx_pkg::ST_PAD;
                            end
                            else
                            begin
                                idx_r <= 2'(idx_r + 2'd1);
                                state_r <= lsx_pkg::ST_XFER;
                            end
                        end
                    end
                end
                lsx_pkg::ST_INC_WRITE:
                begin
                    if (!mem_req_r)
                    begin
                        mem_req_r <= 1'b1;
                        mem_we_r <= 1'b1;
                    end
                    else if (mem_ack)
                    begin
                        mem_req_r <= 1'b0;
                        mem_we_r <= 1'b0;
                        state_r <= lsx_pkg::ST_PAD;
                    end
                end
                lsx_pkg::ST_PAD:
                begin
                    // Stretch to the nominal instruction time
                    if (cyc_r >= 8'(target_cyc - 8'h01))
                    begin
                        state_r <= lsx_pkg::ST_DONE;
                    end
                end
                lsx_pkg::ST_DONE:
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    skip_r <= is_inc && skip_pend_r;
                    state_r <= lsx_pkg::ST_IDLE;
                end
                default:
                begin
                    state_r <= lsx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign skip = skip_r;
    assign illegal = illegal_r;
    assign mem_req = mem_req_r;
    assign mem_we = mem_we_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign a_we = a_we_r;
    assign a_out = a_out_r;
    assign d_we = d_we_r;
    assign d_out = d_out_r;
    assign t_we = t_we_r;
    assign t_out = t_out_r;
    assign x_we = x_we_r;
    assign x_out = x_out_r;
endmodule

/* shared/lsx_pkg.sv */
package lsx_pkg;
    // Opcode field: bits 15..11 of the instruction
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 11;
    localparam logic [4:0] OPC_STORE_ZERO = 5'h00;
    localparam logic [4:0] OPC_STORE_ACC = 5'h01;
    localparam logic [4:0] OPC_STORE_TEMP = 5'h02;
    localparam logic [4:0] OPC_STORE_INDEX = 5'h03;
    localparam logic [4:0] OPC_STORE_DOUBLE = 5'h04;
    localparam logic [4:0] OPC_LOAD_DOUBLE = 5'h05;
    localparam logic [4:0] OPC_STORE_FLOAT = 5'h06;
    localparam logic [4:0] OPC_LOAD_FLOAT = 5'h07;
    localparam logic [4:0] OPC_INC_SKIP = 5'h08;
    localparam logic [4:0] OPC_LOAD_ACC = 5'h09;
    localparam logic [4:0] OPC_LOAD_TEMP = 5'h0a;
    localparam logic [4:0] OPC_LOAD_INDEX = 5'h0b;
    // Address mode bits
    localparam int BIT_X = 10;
    localparam int BIT_I = 9;
    localparam int BIT_B = 8;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Nominal execution times in ns and cycle counts at 50 MHz
    localparam int CLK_NS = 20;
    localparam int T_STORE_NS = 1300;
    localparam int T_STORE_DOUBLE_NS = 2200;
    localparam int T_STORE_FLOAT_NS = 2800;
    localparam int T_INC_SKIP_NS = 2900;
    localparam int T_INC_NOSKIP_NS = 2600;
    localparam int T_LOAD_NS = 1000;
    localparam int T_LOAD_DOUBLE_NS = 1600;
    localparam int T_LOAD_FLOAT_NS = 2000;
    localparam logic [7:0] CYC_STORE = 8'(T_STORE_NS / CLK_NS);
    localparam logic [7:0] CYC_STORE_DOUBLE = 8'(T_STORE_DOUBLE_NS / CLK_NS);
    localparam logic [7:0] CYC_STORE_FLOAT = 8'(T_STORE_FLOAT_NS / CLK_NS);
    localparam logic [7:0] CYC_INC_SKIP = 8'(T_INC_SKIP_NS / CLK_NS);
    localparam logic [7:0] CYC_INC_NOSKIP = 8'(T_INC_NOSKIP_NS / CLK_NS);
    localparam logic [7:0] CYC_LOAD = 8'(T_LOAD_NS / CLK_NS);
    localparam logic [7:0] CYC_LOAD_DOUBLE = 8'(T_LOAD_DOUBLE_NS / CLK_NS);
    localparam logic [7:0] CYC_LOAD_FLOAT = 8'(T_LOAD_FLOAT_NS / CLK_NS);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_PTR_REQ = 4'b0001,
        ST_PTR_WAIT = 4'b0010,
        ST_XFER = 4'b0011,
        ST_XFER_WAIT = 4'b0100,
        ST_INC_WRITE = 4'b0101,
        ST_PAD = 4'b0110,
        ST_DONE = 4'b0111
    } lsx_state_t;
endpackage

/* verif/lsx_exec_sva.sv */
`timescale 1ns/1ps
module lsx_exec_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] a_in,
    input wire logic busy,
    input wire logic done,
    input wire logic skip,
    input wire logic illegal,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic a_we,
    input wire logic d_we,
    input wire logic t_we,
    input wire logic x_we
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [4:0] opc_r;
    logic [15:0] a_r;
    // Opcode and A as taken at the accepted start
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            opc_r <= 5'h1f;
            a_r <= 16'h0000;
        end
        else if (start && !busy)
        begin
            opc_r <= instr[15:11];
            a_r <= a_in;
        end
    end
    wire is_store = opc_r <= lsx_pkg::OPC_STORE_DOUBLE || opc_r == lsx_pkg::OPC_STORE_FLOAT;
    wire is_load = opc_r >= lsx_pkg::OPC_LOAD_ACC && opc_r <= lsx_pkg::OPC_LOAD_INDEX;
    wire reg_we = a_we || d_we || t_we || x_we;
    a_done_after_busy: assert property (done |-> $past(busy))
        else $error("done without a running instruction");
    a_done_single: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_skip_inc_only: assert property (skip |-> done && opc_r == lsx_pkg::OPC_INC_SKIP)
        else $error("skip outside increment completion");
    a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before ack");
    a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("no gap after memory ack");
    a_zero_data: assert property (mem_req && mem_we && opc_r == lsx_pkg::OPC_STORE_ZERO
        |-> mem_wdata == lsx_pkg::WORD_ZERO)
        else $error("store zero wrote nonzero");
    a_acc_data: assert property (mem_req && mem_we && opc_r == lsx_pkg::OPC_STORE_ACC
        |-> mem_wdata == a_r)
        else $error("store accumulator data differs from A");
    a_store_no_reg: assert property (busy && is_store |-> !reg_we)
        else $error("store wrote a register");
    a_load_no_write: assert property (mem_req && is_load |-> !mem_we)
        else $error("load wrote memory");
    a_x_only_ldx: assert property (x_we |-> opc_r == lsx_pkg::OPC_LOAD_INDEX)
        else $error("X written by other instruction");
    a_illegal_pulse: assert property (start && !busy && instr[15:11] > 5'h0b
        |-> ##[1:2] illegal)
        else $error("unknown opcode not flagged");
    c_skip: cover property (skip);
    c_slow_mem: cover property (mem_req && !mem_ack);
    c_illegal: cover property (illegal);
endmodule

bind lsx_exec lsx_exec_sva u_sva (.clock(clock), .rst(rst), .start(start), .instr(instr),
    .a_in(a_in), .busy(busy), .done(done), .skip(skip), .illegal(illegal),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .a_we(a_we), .d_we(d_we), .t_we(t_we), .x_we(x_we));

/* verif/lsx_mem_model.sv */
`timescale 1ns/1ps
module lsx_mem_model (
    input wire logic clock,
    input wire logic [3:0] wait_cyc,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:65535];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    // Ack once the request has stood wait_cyc cycles
    assign mem_ack = mem_req && (cnt >= wait_cyc);
    // Outside an ack the data lines show the inverse of the last word
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~last;
    always @(posedge clock)
    begin
        cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
        if (mem_ack)
        begin
            last <= mem_we ? mem_wdata : mem[mem_addr];
            if (mem_we)
                mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [15:0] pc = 16'h0100;
    logic [15:0] reg_b = 16'h1000;
    logic [15:0] a_in = 16'ha001;
    logic [15:0] d_in = 16'hd002;
    logic [15:0] t_in = 16'h7003;
    logic [15:0] x_in = 16'h0010;
    logic [3:0] wait_cyc = 4'h0;
    logic mem_ack, busy, done, skip, illegal, mem_req, mem_we, a_we, d_we, t_we, x_we, sk;
    logic [15:0] mem_rdata, mem_addr, mem_wdata, a_out, d_out, t_out, x_out;
    logic [15:0] a_got, d_got, t_got, x_got;
    int n_fail = 0;
    int tests_run = 0;
    int n;
    always #10 clock = ~clock;
    lsx_exec DUT (.clock(clock), .rst(rst), .start(start), .instr(instr), .pc(pc),
        .reg_b(reg_b), .a_in(a_in), .d_in(d_in), .t_in(t_in), .x_in(x_in),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done), .skip(skip),
        .illegal(illegal), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .a_we(a_we), .a_out(a_out), .d_we(d_we), .d_out(d_out),
        .t_we(t_we), .t_out(t_out), .x_we(x_we), .x_out(x_out));
    lsx_mem_model M (.clock(clock), .wait_cyc(wait_cyc), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // Register file stand-in: keeps what each write pulse delivers
    always @(posedge clock)
    begin
        if (a_we) a_got <= a_out;
        if (d_we) d_got <= d_out;
        if (t_we) t_got <= t_out;
        if (x_we) x_got <= x_out;
    end
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Issue one instruction; n counts edges after the start edge until done
    task automatic run(input logic [4:0] op, input logic [2:0] md, input logic [7:0] dp);
        @(negedge clock);
        instr = {op, md, dp};
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        // X moves once under way; the design must keep the X taken at start
        x_in = ~x_in;
        sk = 1'b0;
        for (n = 1; n < 400; n++)
        begin
            @(negedge clock);
            if (done === 1'b1)
            begin
                sk = skip;
                break;
            end
        end
        x_in = ~x_in;
    endtask
    task automatic t_store();
        logic [4:0] ops [4] = '{lsx_pkg::OPC_STORE_ZERO, lsx_pkg::OPC_STORE_ACC,
            lsx_pkg::OPC_STORE_TEMP, lsx_pkg::OPC_STORE_INDEX};
        logic [15:0] ex [4] = '{lsx_pkg::WORD_ZERO, a_in, t_in, x_in};
        for (int i = 0; i < 4; i++)
        begin
            M.mem[16'h0110 + 16'(i)] = 16'h5a5a;
            run(ops[i], 3'h0, 8'h10 + 8'(i));
            chk("store word", M.mem[16'h0110 + 16'(i)], ex[i]);
            chk("store time", 16'(n), {8'h00, lsx_pkg::CYC_STORE});
        end
        run(lsx_pkg::OPC_STORE_INDEX, 3'h4, 8'h05);
        chk("indexed store x", M.mem[16'h0015], x_in);
    endtask
    task automatic t_multi();
        run(lsx_pkg::OPC_STORE_DOUBLE, 3'h1, 8'hfe);
        chk("double low", M.mem[16'h0ffe], a_in);
        chk("double high", M.mem[16'h0fff], d_in);
        chk("double time", 16'(n), {8'h00, lsx_pkg::CYC_STORE_DOUBLE});
        run(lsx_pkg::OPC_STORE_FLOAT, 3'h0, 8'h20);
        chk("float exp", M.mem[16'h0120], t_in);
        chk("float w1", M.mem[16'h0121], a_in);
        chk("float w2", M.mem[16'h0122], d_in);
        chk("float time", 16'(n), {8'h00, lsx_pkg::CYC_STORE_FLOAT});
    endtask
    task automatic t_inc();
        M.mem[16'h0130] = 16'hffff;
        M.mem[16'h0131] = 16'h0007;
        run(lsx_pkg::OPC_INC_SKIP, 3'h0, 8'h30);
        chk("inc wrap", M.mem[16'h0130], 16'h0000);
        chk("inc skip", {15'h0000, sk}, 16'h0001);
        chk("inc skip time", 16'(n), {8'h00, lsx_pkg::CYC_INC_SKIP});
        run(lsx_pkg::OPC_INC_SKIP, 3'h0, 8'h31);
        chk("inc word", M.mem[16'h0131], 16'h0008);
        chk("inc noskip", {15'h0000, sk}, 16'h0000);
        chk("inc time", 16'(n), {8'h00, lsx_pkg::CYC_INC_NOSKIP});
    endtask
    task automatic t_load();
        M.mem[16'h1013] = 16'h1234;
        run(lsx_pkg::OPC_LOAD_ACC, 3'h5, 8'h03);
        chk("load a", a_got, 16'h1234);
        chk("load time", 16'(n), {8'h00, lsx_pkg::CYC_LOAD});
        M.mem[16'h1004] = 16'h2000;
        M.mem[16'h2010] = 16'h4321;
        run(lsx_pkg::OPC_LOAD_TEMP, 3'h7, 8'h04);
        chk("load t", t_got, 16'h4321);
        M.mem[16'h0160] = 16'h0170;
        M.mem[16'h0170] = 16'h6666;
        run(lsx_pkg::OPC_LOAD_ACC, 3'h2, 8'h60);
        chk("load ind p", a_got, 16'h6666);
        M.mem[16'h1008] = 16'h0180;
        M.mem[16'h0180] = 16'h0abc;
        run(lsx_pkg::OPC_LOAD_ACC, 3'h3, 8'h08);
        chk("load ind b", a_got, 16'h0abc);
        M.mem[16'h0102] = 16'h0002;
        M.mem[16'h0012] = 16'h7777;
        run(lsx_pkg::OPC_LOAD_INDEX, 3'h6, 8'h02);
        chk("load x", x_got, 16'h7777);
        M.mem[16'h0140] = 16'h1111;
        M.mem[16'h0141] = 16'h2222;
        run(lsx_pkg::OPC_LOAD_DOUBLE, 3'h0, 8'h40);
        chk("ldd a", a_got, 16'h1111);
        chk("ldd d", d_got, 16'h2222);
        chk("ldd time", 16'(n), {8'h00, lsx_pkg::CYC_LOAD_DOUBLE});
        M.mem[16'h0150] = 16'h3333;
        M.mem[16'h0151] = 16'h4444;
        M.mem[16'h0152] = 16'h5555;
        wait_cyc = 4'h3;
        run(lsx_pkg::OPC_LOAD_FLOAT, 3'h0, 8'h50);
        wait_cyc = 4'h0;
        chk("ldf t", t_got, 16'h3333);
        chk("ldf a", a_got, 16'h4444);
        chk("ldf d", d_got, 16'h5555);
        chk("ldf time", 16'(n), {8'h00, lsx_pkg::CYC_LOAD_FLOAT});
    endtask
    task automatic t_illegal();
        logic il = 1'b0;
        logic bz = 1'b0;
        @(negedge clock);
        instr = {5'h1f, 11'h000};
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        repeat (3)
        begin
            il = il | (illegal === 1'b1);
            bz = bz | (busy !== 1'b0);
            @(negedge clock);
        end
        chk("illegal flag", {14'h0000, il, bz}, 16'h0002);
    endtask
    task automatic test_done();
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        t_store();
        t_multi();
        t_inc();
        t_load();
        t_illegal();
        test_done();
    end
    // About 1330 cycles are expected; cut off at 20000
    initial
    begin
        #400000;
        n_fail++;
        test_done();
    end
endmodule
